// [rtl/tcc_regs.vh]
// register indices, field positions, reset values and timing counts
// byte address of a register is four times its index
`ifndef TCC_REGS_VH
`define TCC_REGS_VH
`define TCC_IDX_CNT_A 6'h10
`define TCC_IDX_CNT_B 6'h11
`define TCC_IDX_PER_A 6'h12
`define TCC_IDX_PER_B 6'h13
`define TCC_IDX_WIDE_LO 6'h14
`define TCC_IDX_WIDE_HI 6'h15
`define TCC_IDX_CTRL1 6'h16
`define TCC_IDX_CTRL2 6'h17
`define TCC_IDX_CTRL3 6'h18
`define TCC_IDX_CAP_LO 6'h19
`define TCC_IDX_CAP_HI 6'h1a
`define TCC_IDX_IRQ_FLAG 6'h21
`define TCC_IDX_IRQ_EN 6'h22
`define TCC_IDX_PIN_CFG 6'h23
`define TCC_CTRL_RESET 8'h00
`define TCC_CONCAT_BIT 3
`define TCC_WIDE_CS_BIT 2
`define TCC_B_CS_BIT 1
`define TCC_A_CS_BIT 0
`define TCC_CAP_SEL_BIT 3
`define TCC_WIDE_RUN_BIT 2
`define TCC_B_RUN_BIT 1
`define TCC_A_RUN_BIT 0
`define TCC_CTRL2_WMASK 8'h3f
`define TCC_CTRL3_WMASK 8'h1f
`define TCC_EDGE_FALL 2'b00
`define TCC_EDGE_RISE 2'b01
`define TCC_EDGE_RISE4 2'b10
`define TCC_EDGE_RISE16 2'b11
`define TCC_TCY_DIV 2'd3
`endif

// [rtl/tcc_timer_capture_control.v]
// timers a and b, wide timer, four capture channels, pulse pin control
// assumes an apb3 master on pclk; pins are synchronised to pclk inside by two flops
//
// Contract
// - two 8-bit up timers, each with period register and own flag.
// - 16-bit wide timer plus pair serving as its period or capture.
// - all four capture channels sample the wide timer count.
// - edge mode 00 fall, 01 rise, 10 every 4th, 11 every 16th rise.
// - concat bit set joins timers b and a into one 16-bit timer.
// - wide timer clock select: 0 internal, 1 falling edges of its pin.
// - timer a and b clock select: 0 internal, 1 shared pin falling.
// - capture while unread sets overrun and keeps the older value.
// - capture overrun bits are read only at their fixed positions.
// - pulse enable forces pin output, else direction bit controls it.
// - select bit makes pair capture a when 1, wide period when 0.
// - wide timer run bit starts and stops counting.
// - in concat mode upper byte increments only while timer b runs.
// - timer a run bit starts combined timer, or timer a alone.
// - internal clock increments once per instruction cycle.
// - 8-bit timer counts to period, then wraps to zero, sets flag.
// - each 8-bit timer latches its own distinct flag.
// - irq gated by own enable, peripheral enable, global disable.
// - stopped timer holds count and never sets its flag.
// - pulse a uses timer a; pulses b and c choose timer a or b.
// - concat timer matches 16-bit period, wraps to zero, flags a.
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "tcc_regs.vh"
module tcc_timer_capture_control (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire shared_count_pin,
    input wire wide_timer_count_pin,
    input wire [3:0] cap_pin,
    output reg [2:0] pulse_pin_out,
    output reg [2:0] pulse_pin_oe,
    output reg irq
);
    reg [7:0] cnt_a;
    reg [7:0] cnt_b;
    reg [7:0] timer_a_period;
    reg [7:0] timer_b_period;
    reg [15:0] wide_cnt;
    reg [7:0] ctrl1;
    reg [7:0] ctrl2;
    reg [7:0] ctrl3;
    reg timer_a_irq_flag;
    reg timer_b_irq_flag;
    reg [3:0] irq_en;
    reg [7:0] pin_cfg;
    reg [1:0] tcy_cnt;
    reg [2:0] pulse_level;
    reg [2:0] shared_sync;
    reg [2:0] wide_sync;
    reg [7:0] next_rdata;
    reg next_mapped;
    wire [15:0] cap_val [0:3];
    wire [3:0] cap_ovr;

    // apb decode; a transfer completes when pready is seen high
    wire [5:0] idx = paddr[7:2];
    wire xfer = psel & penable & pready;
    wire wr = xfer & pwrite;
    wire rd = xfer & ~pwrite;
    wire wr_cnt_a = wr && idx == `TCC_IDX_CNT_A;
    wire wr_cnt_b = wr && idx == `TCC_IDX_CNT_B;
    wire wr_wlo = wr && idx == `TCC_IDX_WIDE_LO;
    wire wr_whi = wr && idx == `TCC_IDX_WIDE_HI;

    // control fields
    wire concat_mode = ctrl1[`TCC_CONCAT_BIT];
    wire wide_timer_clk_sel = ctrl1[`TCC_WIDE_CS_BIT];
    wire timer_b_clk_sel = ctrl1[`TCC_B_CS_BIT];
    wire timer_a_clk_sel = ctrl1[`TCC_A_CS_BIT];
    wire capture_or_period_sel = ctrl2[`TCC_CAP_SEL_BIT];
    wire wide_timer_run = ctrl2[`TCC_WIDE_RUN_BIT];
    wire timer_b_run = ctrl2[`TCC_B_RUN_BIT];
    wire timer_a_run = ctrl2[`TCC_A_RUN_BIT];
    wire [2:0] pulse_en = {ctrl3[0], ctrl2[5], ctrl2[4]};
    wire [7:0] edge_modes = {ctrl3[4:3], ctrl3[2:1], ctrl1[7:6], ctrl1[5:4]};

    // instruction cycle enable, a quarter of the pclk rate
    wire tcy_tick = tcy_cnt == `TCC_TCY_DIV;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcy_cnt <= 2'd0;
        end else begin
            tcy_cnt <= tcy_cnt + 2'd1;
        end
    end

    // count pins: two flops to synchronise, third for edge history
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_sync <= 3'b111;
            wide_sync <= 3'b111;
        end else begin
            shared_sync <= {shared_sync[1:0], shared_count_pin};
            wide_sync <= {wide_sync[1:0], wide_timer_count_pin};
        end
    end
    wire shared_fall = shared_sync[2] & ~shared_sync[1];
    wire wide_fall = wide_sync[2] & ~wide_sync[1];

    // tick sources; external ticks run at pclk rate, not gated by tcy
    wire tick_a = timer_a_clk_sel ? shared_fall : tcy_tick;
    wire tick_b = timer_b_clk_sel ? shared_fall : tcy_tick;
    wire run_a_tick = timer_a_run & tick_a;
    wire run_b_tick = timer_b_run & tick_b;
    wire cat_match = {cnt_b, cnt_a} == {timer_b_period, timer_a_period};
    wire ev_a = run_a_tick & (concat_mode ? cat_match : cnt_a == timer_a_period);
    wire ev_b = ~concat_mode & run_b_tick & (cnt_b == timer_b_period);

    // timer a: 8-bit, or low byte of the joined timer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_a <= 8'h00;
        end else if (wr_cnt_a) begin
            cnt_a <= pwdata[7:0];
        end else if (run_a_tick) begin
            cnt_a <= ev_a ? 8'h00 : cnt_a + 8'h01;
        end
    end

    // timer b: 8-bit, or high byte carried from timer a
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_b <= 8'h00;
        end else if (wr_cnt_b) begin
            cnt_b <= pwdata[7:0];
        end else if (concat_mode) begin
            if (ev_a) begin
                cnt_b <= 8'h00;
            end else if (run_a_tick && cnt_a == 8'hff && timer_b_run) begin
                cnt_b <= cnt_b + 8'h01;
            end
        end else if (run_b_tick) begin
            cnt_b <= ev_b ? 8'h00 : cnt_b + 8'h01;
        end
    end

    // flags: a software clear loses to an event in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_a_irq_flag <= 1'b0;
            timer_b_irq_flag <= 1'b0;
        end else begin
            if (wr && idx == `TCC_IDX_IRQ_FLAG && pwdata[0]) begin
                timer_a_irq_flag <= 1'b0;
            end
            if (wr && idx == `TCC_IDX_IRQ_FLAG && pwdata[1]) begin
                timer_b_irq_flag <= 1'b0;
            end
            if (ev_a) begin
                timer_a_irq_flag <= 1'b1;
            end
            if (ev_b) begin
                timer_b_irq_flag <= 1'b1;
            end
        end
    end

    // wide timer; free runs when the pair serves as capture a
    wire tick_w = wide_timer_clk_sel ? wide_fall : tcy_tick;
    wire run_w = wide_timer_run & tick_w;
    wire wide_match = ~capture_or_period_sel & (wide_cnt == cap_val[0]);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wide_cnt <= 16'h0000;
        end else if (wr_wlo) begin
            wide_cnt[7:0] <= pwdata[7:0];
        end else if (wr_whi) begin
            wide_cnt[15:8] <= pwdata[7:0];
        end else if (run_w) begin
            wide_cnt <= wide_match ? 16'h0000 : wide_cnt + 16'h0001;
        end
    end

    // capture channels; channel 0 is also the wide timer period
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_cap
            reg [2:0] sync;
            reg [3:0] pre;
            reg [15:0] val;
            reg full;
            reg ovr;
            reg lo_seen;
            reg hi_seen;
            wire [1:0] mode = edge_modes[2*i+1:2*i];
            wire rise = ~sync[2] & sync[1];
            wire fall = sync[2] & ~sync[1];
            wire active = (i != 0) | capture_or_period_sel;
            wire rd_lo = rd && idx == `TCC_IDX_CAP_LO + 2 * i;
            wire rd_hi = rd && idx == `TCC_IDX_CAP_HI + 2 * i;
            wire wr_lo = wr && idx == `TCC_IDX_CAP_LO + 2 * i;
            wire wr_hi = wr && idx == `TCC_IDX_CAP_HI + 2 * i;
            wire read_done = full & (lo_seen | rd_lo) & (hi_seen | rd_hi);
            reg ev;
            always @* begin
                case (mode)
                    `TCC_EDGE_FALL: ev = fall;
                    `TCC_EDGE_RISE: ev = rise;
                    `TCC_EDGE_RISE4: ev = rise & (pre[1:0] == 2'b11);
                    `TCC_EDGE_RISE16: ev = rise & (pre == 4'hf);
                    default: ev = 1'b0;
                endcase
            end
            wire cap_ev = active & ev;
            // rising-edge prescaler, shared by the every-4th and 16th modes
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync <= 3'b000;
                    pre <= 4'h0;
                end else begin
                    sync <= {sync[1:0], cap_pin[i]};
                    if (rise) begin
                        pre <= pre + 4'h1;
                    end
                end
            end
            // a new capture waits until both bytes of the last were read
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    val <= 16'h0000;
                    full <= 1'b0;
                    ovr <= 1'b0;
                    lo_seen <= 1'b0;
                    hi_seen <= 1'b0;
                end else if (cap_ev && !full) begin
                    val <= wide_cnt;
                    full <= 1'b1;
                    lo_seen <= 1'b0;
                    hi_seen <= 1'b0;
                end else begin
                    if (i == 0 && !capture_or_period_sel && wr_lo) begin
                        val[7:0] <= pwdata[7:0];
                    end
                    if (i == 0 && !capture_or_period_sel && wr_hi) begin
                        val[15:8] <= pwdata[7:0];
                    end
                    if (cap_ev) begin
                        ovr <= 1'b1;
                    end else if (read_done) begin
                        ovr <= 1'b0;
                    end
                    if (read_done && !cap_ev) begin
                        full <= 1'b0;
                    end
                    if (rd_lo) begin
                        lo_seen <= 1'b1;
                    end
                    if (rd_hi) begin
                        hi_seen <= 1'b1;
                    end
                end
            end
            assign cap_val[i] = val;
            assign cap_ovr[i] = ovr;
        end
    endgenerate

    // control and configuration registers; overrun bits are not stored here
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1 <= `TCC_CTRL_RESET;
            ctrl2 <= `TCC_CTRL_RESET;
            ctrl3 <= `TCC_CTRL_RESET;
            timer_a_period <= 8'h00;
            timer_b_period <= 8'h00;
            irq_en <= 4'h0;
            pin_cfg <= 8'h00;
        end else if (wr) begin
            case (idx)
                `TCC_IDX_CTRL1: ctrl1 <= pwdata[7:0];
                `TCC_IDX_CTRL2: ctrl2 <= pwdata[7:0] & `TCC_CTRL2_WMASK;
                `TCC_IDX_CTRL3: ctrl3 <= pwdata[7:0] & `TCC_CTRL3_WMASK;
                `TCC_IDX_PER_A: timer_a_period <= pwdata[7:0];
                `TCC_IDX_PER_B: timer_b_period <= pwdata[7:0];
                `TCC_IDX_IRQ_EN: irq_en <= pwdata[3:0];
                `TCC_IDX_PIN_CFG: pin_cfg <= pwdata[7:0];
                default: ctrl1 <= ctrl1;
            endcase
        end
    end

    // read mux; channel overrun bits sit in the control registers
    always @* begin
        next_rdata = 8'h00;
        next_mapped = 1'b1;
        case (idx)
            `TCC_IDX_CNT_A: next_rdata = cnt_a;
            `TCC_IDX_CNT_B: next_rdata = cnt_b;
            `TCC_IDX_PER_A: next_rdata = timer_a_period;
            `TCC_IDX_PER_B: next_rdata = timer_b_period;
            `TCC_IDX_WIDE_LO: next_rdata = wide_cnt[7:0];
            `TCC_IDX_WIDE_HI: next_rdata = wide_cnt[15:8];
            `TCC_IDX_CTRL1: next_rdata = ctrl1;
            `TCC_IDX_CTRL2: next_rdata = {cap_ovr[1], cap_ovr[0], ctrl2[5:0]};
            `TCC_IDX_CTRL3: next_rdata = {1'b0, cap_ovr[3], cap_ovr[2], ctrl3[4:0]};
            6'h19: next_rdata = cap_val[0][7:0];
            6'h1a: next_rdata = cap_val[0][15:8];
            6'h1b: next_rdata = cap_val[1][7:0];
            6'h1c: next_rdata = cap_val[1][15:8];
            6'h1d: next_rdata = cap_val[2][7:0];
            6'h1e: next_rdata = cap_val[2][15:8];
            6'h1f: next_rdata = cap_val[3][7:0];
            6'h20: next_rdata = cap_val[3][15:8];
            `TCC_IDX_IRQ_FLAG: next_rdata = {6'h00, timer_b_irq_flag, timer_a_irq_flag};
            `TCC_IDX_IRQ_EN: next_rdata = {4'h0, irq_en};
            `TCC_IDX_PIN_CFG: next_rdata = pin_cfg;
            default: next_mapped = 1'b0;
        endcase
    end

    // one wait state buys registered outputs on every apb answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~next_mapped;
            prdata <= {24'h000000, next_rdata};
        end
    end

    // pulse levels toggle on their base timer's period event
    wire [2:0] base_ev = {pin_cfg[4] ? ev_b : ev_a, pin_cfg[3] ? ev_b : ev_a, ev_a};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_level <= 3'b000;
            pulse_pin_out <= 3'b000;
            pulse_pin_oe <= 3'b000;
            irq <= 1'b0;
        end else begin
            pulse_level <= pulse_level ^ base_ev;
            pulse_pin_out <= (pulse_en & pulse_level) | (~pulse_en & pin_cfg[7:5]);
            pulse_pin_oe <= pulse_en | pin_cfg[2:0];
            irq <= ((timer_a_irq_flag & irq_en[0]) | (timer_b_irq_flag & irq_en[1]))
                & irq_en[2] & ~irq_en[3];
        end
    end
endmodule // tcc_timer_capture_control
`default_nettype wire

// [dv/tcc_checker.sv]
// assertions on the apb port, pin enables and irq of the timer block
// bound to the top module; includes the register header from rtl/
`timescale 1ns/10ps
`default_nettype none
`include "tcc_regs.vh"
module tcc_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [2:0] pulse_pin_oe,
    input wire irq
);
    logic [2:0] en_sh;
    logic [2:0] dir_sh;
    logic [3:0] ien_sh;
    logic [2:0] oe_want;
    logic [5:0] idx;
    assign idx = paddr[7:2];
    assign oe_want = en_sh | dir_sh;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // shadow copies of enables, taken when a write completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_sh <= 3'h0;
            dir_sh <= 3'h0;
            ien_sh <= 4'h0;
        end else if (psel && penable && pready && pwrite) begin
            if (idx == `TCC_IDX_CTRL2) en_sh[1:0] <= pwdata[5:4];
            if (idx == `TCC_IDX_CTRL3) en_sh[2] <= pwdata[0];
            if (idx == `TCC_IDX_PIN_CFG) dir_sh <= pwdata[2:0];
            if (idx == `TCC_IDX_IRQ_EN) ien_sh <= pwdata[3:0];
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        penable && !pready ##1 pready;
    endsequence
    a_ready_wait: assert property (s_setup |=> s_access)
        else $error("apb answer not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel && penable) && psel && penable)
        else $error("pready without an access phase");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    a_slverr_map: assert property (pready |-> pslverr == (idx < 6'h10 || idx > 6'h23))
        else $error("pslverr does not match the address map");
    a_ctrl3_top: assert property (pready && !pwrite && idx == `TCC_IDX_CTRL3 |-> !prdata[7])
        else $error("unused control bit reads as one");
    a_oe_follow: assert property ($changed(oe_want) |-> ##[1:3] pulse_pin_oe == oe_want)
        else $error("pin enable does not follow pulse enable and direction");
    a_oe_steady: assert property ($stable(oe_want) [*4] |-> pulse_pin_oe == oe_want)
        else $error("pin enable drifted from its settings");
    a_irq_gate: assert property ((!ien_sh[2] || ien_sh[3] || ien_sh[1:0] == 2'b00) [*2] |-> !irq)
        else $error("irq raised while gated off");
endmodule // tcc_checker
bind tcc_timer_capture_control tcc_checker i_tcc_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_pin_oe(pulse_pin_oe), .irq(irq));
`default_nettype wire

// [dv/tcc_pin_source.sv]
// stand-in for the sources of the count and capture pins
// driven by tb_top through its task; changes land just after pclk rises
`timescale 1ns/10ps
`default_nettype none
module tcc_pin_source (
    input wire logic pclk,
    output logic shared_count_pin,
    output logic wide_timer_count_pin,
    output logic [3:0] cap_pin
);
    // count pins idle high so each pulse gives one falling edge
    initial begin
        shared_count_pin = 1'b1;
        wide_timer_count_pin = 1'b1;
        cap_pin = 4'h0;
    end
    // level held four cycles, longer than the pin sync chain needs
    task automatic drive(input int pin, input logic lvl);
        @(posedge pclk);
        case (pin)
            0: shared_count_pin <= lvl;
            1: wide_timer_count_pin <= lvl;
            default: cap_pin[pin-2] <= lvl;
        endcase
        repeat (4) @(posedge pclk);
    endtask
endmodule // tcc_pin_source
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the timer capture control block
// assumes the pin source model and the bound checker are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "tcc_regs.vh"
module tb_top;
    localparam logic [5:0] CAP_B_LO = 6'h1b;
    localparam logic [5:0] CAP_B_HI = 6'h1c;
    localparam logic [5:0] CAP_D_LO = 6'h1f;
    localparam logic [5:0] CAP_D_HI = 6'h20;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr, rd;
    logic [31:0] pwdata, prdata;
    logic shared_count_pin, wide_timer_count_pin;
    logic [3:0] cap_pin;
    logic [2:0] pulse_pin_out, pulse_pin_oe;
    logic [15:0] w;
    int num_errors, checks;
    tcc_timer_capture_control i_tcc_timer_capture_control (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .shared_count_pin(shared_count_pin), .wide_timer_count_pin(wide_timer_count_pin),
        .cap_pin(cap_pin), .pulse_pin_out(pulse_pin_out), .pulse_pin_oe(pulse_pin_oe), .irq(irq));
    tcc_pin_source i_tcc_pin_source (.pclk(pclk), .shared_count_pin(shared_count_pin),
        .wide_timer_count_pin(wide_timer_count_pin), .cap_pin(cap_pin));
    // 250 mhz clock
    always #2 pclk = ~pclk;
    task automatic wrap_up();
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, then an idle cycle so psel is never driven twice in a step
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            wrap_up();
        end
        @(posedge pclk);
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check8(rd, exp);
    endtask
    task automatic cnt_pulse(input int pin);
        i_tcc_pin_source.drive(pin, 1'b0);
        i_tcc_pin_source.drive(pin, 1'b1);
    endtask
    task automatic cap_edge(input int ch);
        i_tcc_pin_source.drive(ch + 2, 1'b1);
        i_tcc_pin_source.drive(ch + 2, 1'b0);
    endtask
    task automatic wide_pulse();
        cnt_pulse(1);
        w = w + 16'h1;
    endtask
    task automatic t_regs();
        rdc(`TCC_IDX_CTRL1, 8'h00);
        rdc(`TCC_IDX_CTRL2, 8'h00);
        wr(`TCC_IDX_CTRL2, 8'hc0);
        rdc(`TCC_IDX_CTRL2, 8'h00);
        wr(`TCC_IDX_CTRL3, 8'he0);
        rdc(`TCC_IDX_CTRL3, 8'h00);
        apb(1'b0, 6'h3f, 8'h00);
        check8({7'h0, err}, 8'h01);
    endtask
    task automatic t_irq_timer();
        int n;
        logic [7:0] v;
        n = 0;
        wr(`TCC_IDX_PER_A, 8'h02);
        wr(`TCC_IDX_CNT_A, 8'h00);
        wr(`TCC_IDX_IRQ_EN, 8'h05);
        wr(`TCC_IDX_CTRL2, 8'h01);
        while (irq !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        check8({7'h0, n >= 8 && n <= 16}, 8'h01);
        wr(`TCC_IDX_CTRL2, 8'h00);
        rdc(`TCC_IDX_IRQ_FLAG, 8'h01);
        apb(1'b0, `TCC_IDX_CNT_A, 8'h00);
        v = rd;
        repeat (40) @(posedge pclk);
        rdc(`TCC_IDX_CNT_A, v);
        wr(`TCC_IDX_IRQ_EN, 8'h0d);
        // irq is registered: let the edge that launches the new level pass first
        @(posedge pclk);
        check8({7'h0, irq}, 8'h00);
        wr(`TCC_IDX_IRQ_FLAG, 8'h01);
        rdc(`TCC_IDX_IRQ_FLAG, 8'h00);
    endtask
    task automatic t_counts();
        wr(`TCC_IDX_CTRL1, 8'h02);
        wr(`TCC_IDX_PER_B, 8'hff);
        wr(`TCC_IDX_CNT_B, 8'h00);
        wr(`TCC_IDX_CTRL2, 8'h02);
        repeat (5) cnt_pulse(0);
        rdc(`TCC_IDX_CNT_B, 8'h05);
        wr(`TCC_IDX_CTRL1, 8'h09);
        wr(`TCC_IDX_PER_A, 8'h01);
        wr(`TCC_IDX_PER_B, 8'h01);
        wr(`TCC_IDX_CNT_A, 8'hff);
        wr(`TCC_IDX_CNT_B, 8'h00);
        wr(`TCC_IDX_CTRL2, 8'h03);
        cnt_pulse(0);
        rdc(`TCC_IDX_CNT_B, 8'h01);
        repeat (2) cnt_pulse(0);
        rdc(`TCC_IDX_CNT_A, 8'h00);
        rdc(`TCC_IDX_CNT_B, 8'h00);
        rdc(`TCC_IDX_IRQ_FLAG, 8'h01);
        wr(`TCC_IDX_CTRL2, 8'h01);
        wr(`TCC_IDX_CNT_A, 8'hff);
        cnt_pulse(0);
        rdc(`TCC_IDX_CNT_B, 8'h00);
        wr(`TCC_IDX_CTRL2, 8'h00);
    endtask
    task automatic t_capture();
        logic [1:0] modes[4] = '{2'b11, 2'b10, 2'b01, 2'b00};
        int edges[4] = '{16, 4, 1, 1};
        wr(`TCC_IDX_CTRL1, 8'h04);
        wr(`TCC_IDX_CTRL2, 8'h0c);
        wr(`TCC_IDX_WIDE_LO, 8'h34);
        wr(`TCC_IDX_WIDE_HI, 8'h12);
        w = 16'h1234;
        cap_edge(1);
        wide_pulse();
        cap_edge(1);
        rdc(`TCC_IDX_CTRL2, 8'h8c);
        rdc(CAP_B_LO, 8'h34);
        rdc(CAP_B_HI, 8'h12);
        rdc(`TCC_IDX_CTRL2, 8'h0c);
        cap_edge(1);
        rdc(CAP_B_HI, 8'h12);
        rdc(CAP_B_LO, 8'h35);
        wr(`TCC_IDX_CTRL2, 8'h08);
        cnt_pulse(1);
        rdc(`TCC_IDX_WIDE_LO, 8'h35);
        wr(`TCC_IDX_CTRL2, 8'h0c);
        for (int m = 0; m < 4; m++) begin
            wr(`TCC_IDX_CTRL3, {3'h0, modes[m], 3'h0});
            for (int k = 1; k < edges[m]; k++) cap_edge(3);
            wide_pulse();
            cap_edge(3);
            rdc(CAP_D_LO, w[7:0]);
            rdc(CAP_D_HI, w[15:8]);
        end
        wr(`TCC_IDX_CTRL2, 8'h04);
        wr(`TCC_IDX_CAP_LO, 8'h01);
        wr(`TCC_IDX_CAP_HI, 8'h00);
        wr(`TCC_IDX_WIDE_LO, 8'h00);
        wr(`TCC_IDX_WIDE_HI, 8'h00);
        repeat (2) cnt_pulse(1);
        rdc(`TCC_IDX_WIDE_LO, 8'h00);
    endtask
    task automatic t_pins();
        logic [2:0] p;
        int n;
        n = 0;
        wr(`TCC_IDX_CTRL2, 8'h30);
        wr(`TCC_IDX_CTRL3, 8'h01);
        @(posedge pclk);
        check8({5'h0, pulse_pin_oe}, 8'h07);
        // pulse c on timer b, pulse a and b on timer a, which stays stopped
        wr(`TCC_IDX_PER_B, 8'h00);
        wr(`TCC_IDX_PIN_CFG, 8'h10);
        @(posedge pclk);
        p = pulse_pin_out;
        wr(`TCC_IDX_CTRL2, 8'h32);
        while (pulse_pin_out[2] === p[2] && n < 40) begin
            @(posedge pclk);
            n++;
        end
        wr(`TCC_IDX_CTRL2, 8'h30);
        check8({7'h0, n < 40}, 8'h01);
        check8({6'h0, pulse_pin_out[1:0]}, {6'h0, p[1:0]});
        wr(`TCC_IDX_CTRL2, 8'h00);
        wr(`TCC_IDX_CTRL3, 8'h00);
        wr(`TCC_IDX_PIN_CFG, 8'ha2);
        @(posedge pclk);
        check8({5'h0, pulse_pin_oe}, 8'h02);
        check8({5'h0, pulse_pin_out}, 8'h05);
    endtask
    // reset for five cycles, then the scenarios in turn
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        w = 16'h0;
        num_errors = 0;
        checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_irq_timer();
        t_counts();
        t_capture();
        t_pins();
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
